// ===== hdl/cfq_geometry_query.sv
// cfq_geometry_query: query-mode read port for the flash geometry and
// primary extended tables, with array data passed through otherwise.
// assumes host signals are synchronous to sys_clk_i, one read per cycle.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - offset 027h returns 0018h, sixteen megabyte storage exponent.
// - offsets 028h and 029h each return 0001h, x16 sync interface.
// - offsets 02Ah, 02Bh return 0006h, 0000h: 64-byte program buffer.
// - offset 02Ch returns 0002h: two erase block regions.
// - offsets 02Dh, 02Eh return 007Eh, 0000h: 127 blocks.
// - offsets 02Fh, 030h return 0000h, 0002h: 128 KB blocks.
// - offsets 031h, 032h return 0003h, 0000h: four blocks.
// - offsets 033h, 034h return 0080h, 0000h: 32 KB blocks.
// - offsets 035h to 038h hold no region information.
// - offsets 10Ah to 10Ch return signature 0050h, 0052h, 0049h.
// - offsets 10Dh, 10Eh return version digits 0031h, 0033h.
// - offset 10Fh returns feature low byte 00E6h.
// - feature bits 10 through 31 read zero, bit 31 clear.
// - offset 113h returns 0001h, program after erase suspend.
// - offsets 114h, 115h return 0003h, 0000h: lock bits present.
// - offset 116h returns 0018h, core supply optimum voltage.
// - offset 117h returns 0090h, programming supply optimum voltage.
// - query words use the low lane; high lane reads zero.
// - query command enters query reads; read-array command leaves.
module cfq_geometry_query
  import cfq_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter logic [cfq_pkg::CMD_W-1:0] QUERY_CODE = cfq_pkg::CMD_QUERY,
  parameter logic [cfq_pkg::CMD_W-1:0] ARRAY_CODE = cfq_pkg::CMD_READ_ARRAY
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic wr_i,
  input wire logic [cfq_pkg::CMD_W-1:0] cmd_i,
  input wire logic rd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [cfq_pkg::DATA_W-1:0] array_data_i,
  output logic [cfq_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic rd_valid_o,
  output logic query_mode_o
);
  import cfq_pkg::*;

  generate
    if (ADDR_W < QADDR_W) begin : g_bad_addr
      $error("ADDR_W too narrow for the query offsets");
    end
  endgenerate

  cfq_mode_type mode;
  logic [DATA_W-1:0] rom_word;
  logic in_query_space;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_next;
  logic valid_reg;
  logic valid_next;
  logic qmode_reg;
  logic qmode_next;

  cfq_cmd_decode #(
    .QUERY_CODE(QUERY_CODE),
    .ARRAY_CODE(ARRAY_CODE)
  ) u_decode (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .wr_i(wr_i),
    .cmd_i(cmd_i),
    .mode_o(mode)
  );

  cfq_query_rom u_rom (
    .addr_i(addr_i[QADDR_W-1:0]),
    .word_o(rom_word)
  );

  // upper address bits beyond the table alias nothing: they read zero
  always_comb begin
    in_query_space = 1'b1;
    if (ADDR_W > QADDR_W) begin
      in_query_space = (addr_i >> QADDR_W) == '0;
    end
  end

  // a read in the same cycle as a command sees the old mode
  always_comb begin
    data_next = data_reg;
    valid_next = 1'b0;
    qmode_next = (mode == CFQ_QUERY);
    if (rd_i) begin
      valid_next = 1'b1;
      if (mode == CFQ_QUERY) begin
        // low lane only, high lane zero
        data_next = {{LANE_W{1'b0}}, rom_word[LANE_W-1:0]};
        if (!in_query_space) begin
          data_next = VAL_ZERO;
        end
      end else begin
        data_next = array_data_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      data_reg <= VAL_ZERO;
      valid_reg <= 1'b0;
      qmode_reg <= 1'b0;
    end else if (clk_en_i) begin
      data_reg <= data_next;
      valid_reg <= valid_next;
      qmode_reg <= qmode_next;
    end
  end

  assign data_o = data_reg;
  assign rd_valid_o = valid_reg;
  // bus is driven only during the answer cycle
  assign data_oe_o = valid_reg;
  assign query_mode_o = qmode_reg;

  // checks

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_qrd(logic [ADDR_W-1:0] a);
    clk_en_i && rd_i && mode == CFQ_QUERY && addr_i == a;
  endsequence

  sequence s_enter_query;
    clk_en_i && wr_i && cmd_i == QUERY_CODE && mode == CFQ_ARRAY;
  endsequence

  sequence s_leave_query;
    clk_en_i && wr_i && cmd_i == ARRAY_CODE && mode == CFQ_QUERY;
  endsequence

  a_size_word: assert property (
    s_qrd(ADDR_W'(OFF_SIZE_EXP)) |=> rd_valid_o && data_o == VAL_SIZE_EXP)
    else $error("size exponent word wrong");

  a_ifc_words: assert property (
    s_qrd(ADDR_W'(OFF_IFC_LO)) or s_qrd(ADDR_W'(OFF_IFC_HI))
    |=> data_o == VAL_IFC && data_oe_o)
    else $error("interface code word wrong");

  a_buffer_words: assert property (
    s_qrd(ADDR_W'(OFF_BUF_LO)) ##1 s_qrd(ADDR_W'(OFF_BUF_HI))
    |-> data_o == VAL_BUF_LO ##1 data_o == VAL_ZERO)
    else $error("program buffer words wrong");

  a_region_count: assert property (
    s_qrd(ADDR_W'(OFF_REGION_CNT)) |=> data_o[LANE_W-1:0] == VAL_REGION_CNT[LANE_W-1:0])
    else $error("region count wrong");

  a_r1_blocks: assert property (
    s_qrd(ADDR_W'(OFF_R1_BLK_LO)) |=> data_o == VAL_R1_BLK_LO)
    else $error("region one block count wrong");

  a_r1_blocks_hi: assert property (
    s_qrd(ADDR_W'(OFF_R1_BLK_HI)) |=> data_o == VAL_ZERO)
    else $error("region one block count high wrong");

  a_r1_size: assert property (
    s_qrd(ADDR_W'(OFF_R1_SIZE_LO)) |=> data_o == VAL_ZERO)
    else $error("region one size low wrong");

  a_r1_size_hi: assert property (
    s_qrd(ADDR_W'(OFF_R1_SIZE_HI)) |=> data_o == VAL_R1_SIZE_HI)
    else $error("region one size high wrong");

  a_r2_blocks: assert property (
    s_qrd(ADDR_W'(OFF_R2_BLK_LO)) |=> data_o == VAL_R2_BLK_LO)
    else $error("region two block count wrong");

  a_r2_blocks_hi: assert property (
    s_qrd(ADDR_W'(OFF_R2_BLK_HI)) |=> data_o == VAL_ZERO)
    else $error("region two block count high wrong");

  a_r2_size: assert property (
    s_qrd(ADDR_W'(OFF_R2_SIZE_LO)) |=> data_o == VAL_R2_SIZE_LO)
    else $error("region two size low wrong");

  a_r2_size_hi: assert property (
    s_qrd(ADDR_W'(OFF_R2_SIZE_HI)) |=> data_o == VAL_ZERO)
    else $error("region two size high wrong");

  a_reserved_regions: assert property (
    clk_en_i && rd_i && mode == CFQ_QUERY
    && addr_i >= ADDR_W'(OFF_RSV_FIRST) && addr_i <= ADDR_W'(OFF_RSV_LAST)
    |=> data_o == VAL_ZERO)
    else $error("reserved region word not zero");

  a_signature: assert property (
    s_qrd(ADDR_W'(OFF_SIG_P)) ##1 s_qrd(ADDR_W'(OFF_SIG_R))
    ##1 s_qrd(ADDR_W'(OFF_SIG_I))
    |=> data_o == VAL_SIG_I && $past(data_o) == VAL_SIG_R
    && $past(data_o, 2) == VAL_SIG_P)
    else $error("table signature wrong");

  a_sig_first: assert property (
    s_qrd(ADDR_W'(OFF_SIG_P)) |=> data_o == VAL_SIG_P)
    else $error("signature first letter wrong");

  a_version: assert property (
    s_qrd(ADDR_W'(OFF_VER_MAJOR)) |=> data_o == VAL_VER_MAJOR)
    else $error("major version wrong");

  a_version_minor: assert property (
    s_qrd(ADDR_W'(OFF_VER_MINOR)) |=> data_o == VAL_VER_MINOR)
    else $error("minor version wrong");

  a_feature_low: assert property (
    s_qrd(ADDR_W'(OFF_FEAT_B0)) |=> data_o == VAL_FEAT_B0
    && !data_o[0] && data_o[1] && data_o[2] && !data_o[3])
    else $error("feature low byte wrong");

  a_feature_rsvd: assert property (
    s_qrd(ADDR_W'(OFF_FEAT_B1)) |=> data_o[LANE_W-1:2] == '0)
    else $error("feature bits 10 up not zero");

  a_feature_top: assert property (
    s_qrd(ADDR_W'(OFF_FEAT_B2)) or s_qrd(ADDR_W'(OFF_FEAT_B3))
    |=> data_o == VAL_ZERO)
    else $error("feature upper bytes not zero");

  a_suspend_fn: assert property (
    s_qrd(ADDR_W'(OFF_SUSPEND_FN)) |=> data_o == VAL_SUSPEND_FN)
    else $error("after-suspend word wrong");

  a_protect_bits: assert property (
    s_qrd(ADDR_W'(OFF_PROT_LO)) ##1 s_qrd(ADDR_W'(OFF_PROT_HI))
    |=> data_o == VAL_ZERO && $past(data_o) == VAL_PROT_LO)
    else $error("lock status words wrong");

  a_core_voltage: assert property (
    s_qrd(ADDR_W'(OFF_VDD_OPT)) |=> data_o == VAL_VDD_OPT)
    else $error("core supply word wrong");

  a_prog_voltage: assert property (
    s_qrd(ADDR_W'(OFF_VPP_OPT)) |=> data_o == VAL_VPP_OPT)
    else $error("program supply word wrong");

  a_low_lane: assert property (
    clk_en_i && rd_i && mode == CFQ_QUERY
    |=> data_o[DATA_W-1:LANE_W] == '0 && rd_valid_o)
    else $error("query data on high lane");

  a_mode_enter: assert property (
    s_enter_query ##1 clk_en_i |=> query_mode_o)
    else $error("query mode not entered");

  a_mode_leave: assert property (
    s_leave_query ##1 clk_en_i |=> !query_mode_o)
    else $error("query mode not left");

  a_mode_holds: assert property (
    clk_en_i && mode == CFQ_QUERY && !(wr_i && cmd_i == ARRAY_CODE)
    |=> mode == CFQ_QUERY)
    else $error("query mode dropped without read-array");

  a_array_pass: assert property (
    clk_en_i && rd_i && mode == CFQ_ARRAY |=> data_o == $past(array_data_i))
    else $error("array read not passed through");

  a_unused_zero: assert property (
    clk_en_i && rd_i && mode == CFQ_QUERY && rom_word == VAL_ZERO
    |=> data_o == VAL_ZERO)
    else $error("unused query word not zero");

  a_valid_pulse: assert property (
    clk_en_i && !rd_i ##1 clk_en_i |-> !rd_valid_o && !data_oe_o)
    else $error("answer strobe without read");

  a_freeze: assert property (
    !clk_en_i |=> $stable(data_o) && $stable(rd_valid_o))
    else $error("state moved while clock enable low");

endmodule : cfq_geometry_query
`default_nettype wire

// ===== common/cfq_pkg.sv
// cfq_pkg: offsets, values and command codes for the flash query table.
// assumes word addressing of the query space, 16-bit data bus.
`default_nettype none
package cfq_pkg;
  localparam int QADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int CMD_W = 8;
  // host command codes; plain defaults, overridable at the top
  localparam logic [CMD_W-1:0] CMD_QUERY = 8'h98;
  localparam logic [CMD_W-1:0] CMD_READ_ARRAY = 8'hFF;
  // device geometry section
  localparam logic [QADDR_W-1:0] OFF_SIZE_EXP = 9'h027;
  localparam logic [QADDR_W-1:0] OFF_IFC_LO = 9'h028;
  localparam logic [QADDR_W-1:0] OFF_IFC_HI = 9'h029;
  localparam logic [QADDR_W-1:0] OFF_BUF_LO = 9'h02A;
  localparam logic [QADDR_W-1:0] OFF_BUF_HI = 9'h02B;
  localparam logic [QADDR_W-1:0] OFF_REGION_CNT = 9'h02C;
  localparam logic [QADDR_W-1:0] OFF_R1_BLK_LO = 9'h02D;
  localparam logic [QADDR_W-1:0] OFF_R1_BLK_HI = 9'h02E;
  localparam logic [QADDR_W-1:0] OFF_R1_SIZE_LO = 9'h02F;
  localparam logic [QADDR_W-1:0] OFF_R1_SIZE_HI = 9'h030;
  localparam logic [QADDR_W-1:0] OFF_R2_BLK_LO = 9'h031;
  localparam logic [QADDR_W-1:0] OFF_R2_BLK_HI = 9'h032;
  localparam logic [QADDR_W-1:0] OFF_R2_SIZE_LO = 9'h033;
  localparam logic [QADDR_W-1:0] OFF_R2_SIZE_HI = 9'h034;
  localparam logic [QADDR_W-1:0] OFF_RSV_FIRST = 9'h035;
  localparam logic [QADDR_W-1:0] OFF_RSV_LAST = 9'h038;
  // primary extended table
  localparam logic [QADDR_W-1:0] OFF_SIG_P = 9'h10A;
  localparam logic [QADDR_W-1:0] OFF_SIG_R = 9'h10B;
  localparam logic [QADDR_W-1:0] OFF_SIG_I = 9'h10C;
  localparam logic [QADDR_W-1:0] OFF_VER_MAJOR = 9'h10D;
  localparam logic [QADDR_W-1:0] OFF_VER_MINOR = 9'h10E;
  localparam logic [QADDR_W-1:0] OFF_FEAT_B0 = 9'h10F;
  localparam logic [QADDR_W-1:0] OFF_FEAT_B1 = 9'h110;
  localparam logic [QADDR_W-1:0] OFF_FEAT_B2 = 9'h111;
  localparam logic [QADDR_W-1:0] OFF_FEAT_B3 = 9'h112;
  localparam logic [QADDR_W-1:0] OFF_SUSPEND_FN = 9'h113;
  localparam logic [QADDR_W-1:0] OFF_PROT_LO = 9'h114;
  localparam logic [QADDR_W-1:0] OFF_PROT_HI = 9'h115;
  localparam logic [QADDR_W-1:0] OFF_VDD_OPT = 9'h116;
  localparam logic [QADDR_W-1:0] OFF_VPP_OPT = 9'h117;
  localparam logic [DATA_W-1:0] VAL_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] VAL_SIZE_EXP = 16'h0018;
  localparam logic [DATA_W-1:0] VAL_IFC = 16'h0001;
  localparam logic [DATA_W-1:0] VAL_BUF_LO = 16'h0006;
  localparam logic [DATA_W-1:0] VAL_REGION_CNT = 16'h0002;
  localparam logic [DATA_W-1:0] VAL_R1_BLK_LO = 16'h007E;
  localparam logic [DATA_W-1:0] VAL_R1_SIZE_HI = 16'h0002;
  localparam logic [DATA_W-1:0] VAL_R2_BLK_LO = 16'h0003;
  localparam logic [DATA_W-1:0] VAL_R2_SIZE_LO = 16'h0080;
  localparam logic [DATA_W-1:0] VAL_SIG_P = 16'h0050;
  localparam logic [DATA_W-1:0] VAL_SIG_R = 16'h0052;
  localparam logic [DATA_W-1:0] VAL_SIG_I = 16'h0049;
  localparam logic [DATA_W-1:0] VAL_VER_MAJOR = 16'h0031;
  localparam logic [DATA_W-1:0] VAL_VER_MINOR = 16'h0033;
  localparam logic [DATA_W-1:0] VAL_FEAT_B0 = 16'h00E6;
  localparam logic [DATA_W-1:0] VAL_FEAT_B1 = 16'h0003;
  localparam logic [DATA_W-1:0] VAL_SUSPEND_FN = 16'h0001;
  localparam logic [DATA_W-1:0] VAL_PROT_LO = 16'h0003;
  localparam logic [DATA_W-1:0] VAL_VDD_OPT = 16'h0018;
  localparam logic [DATA_W-1:0] VAL_VPP_OPT = 16'h0090;
  typedef enum logic {CFQ_ARRAY, CFQ_QUERY} cfq_mode_type;
endpackage : cfq_pkg
`default_nettype wire

// ===== hdl/cfq_query_rom.sv
// cfq_query_rom: combinational lookup of one query word by offset.
// assumes the caller registers the result before it reaches a pin.
`timescale 1ns/1ps
`default_nettype none
module cfq_query_rom
  import cfq_pkg::*;
(
  input wire logic [cfq_pkg::QADDR_W-1:0] addr_i,
  output logic [cfq_pkg::DATA_W-1:0] word_o
);
  always_comb begin
    word_o = VAL_ZERO;
    case (addr_i)
      OFF_SIZE_EXP: word_o = VAL_SIZE_EXP;
      OFF_IFC_LO, OFF_IFC_HI: word_o = VAL_IFC;
      OFF_BUF_LO: word_o = VAL_BUF_LO;
      OFF_REGION_CNT: word_o = VAL_REGION_CNT;
      OFF_R1_BLK_LO: word_o = VAL_R1_BLK_LO;
      OFF_R1_SIZE_HI: word_o = VAL_R1_SIZE_HI;
      OFF_R2_BLK_LO: word_o = VAL_R2_BLK_LO;
      OFF_R2_SIZE_LO: word_o = VAL_R2_SIZE_LO;
      OFF_SIG_P: word_o = VAL_SIG_P;
      OFF_SIG_R: word_o = VAL_SIG_R;
      OFF_SIG_I: word_o = VAL_SIG_I;
      OFF_VER_MAJOR: word_o = VAL_VER_MAJOR;
      OFF_VER_MINOR: word_o = VAL_VER_MINOR;
      OFF_FEAT_B0: word_o = VAL_FEAT_B0;
      // bits 8, 9 set; 10 to 31 clear
      OFF_FEAT_B1: word_o = VAL_FEAT_B1;
      OFF_SUSPEND_FN: word_o = VAL_SUSPEND_FN;
      OFF_PROT_LO: word_o = VAL_PROT_LO;
      OFF_VDD_OPT: word_o = VAL_VDD_OPT;
      OFF_VPP_OPT: word_o = VAL_VPP_OPT;
      // reserved and unlisted offsets read zero
      default: word_o = VAL_ZERO;
    endcase
  end
endmodule : cfq_query_rom
`default_nettype wire

// ===== hdl/cfq_cmd_decode.sv
// cfq_cmd_decode: tracks query versus array read mode from host writes.
// assumes one command byte per write strobe, low lane only.
`timescale 1ns/1ps
`default_nettype none
module cfq_cmd_decode
  import cfq_pkg::*;
#(
  parameter logic [cfq_pkg::CMD_W-1:0] QUERY_CODE = cfq_pkg::CMD_QUERY,
  parameter logic [cfq_pkg::CMD_W-1:0] ARRAY_CODE = cfq_pkg::CMD_READ_ARRAY
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic wr_i,
  input wire logic [cfq_pkg::CMD_W-1:0] cmd_i,
  output var cfq_pkg::cfq_mode_type mode_o
);
  cfq_mode_type mode_reg;
  cfq_mode_type mode_next;
  generate
    if (QUERY_CODE == ARRAY_CODE) begin : g_bad_codes
      $error("query and read-array codes must differ");
    end
  endgenerate
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      CFQ_ARRAY: begin
        if (wr_i && cmd_i == QUERY_CODE) begin
          mode_next = CFQ_QUERY;
        end
      end
      CFQ_QUERY: begin
        // other codes leave query data in place
        if (wr_i && cmd_i == ARRAY_CODE) begin
          mode_next = CFQ_ARRAY;
        end
      end
      default: mode_next = CFQ_ARRAY;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mode_reg <= CFQ_ARRAY;
    end else if (clk_en_i) begin
      mode_reg <= mode_next;
    end
  end
  assign mode_o = mode_reg;
endmodule : cfq_cmd_decode
`default_nettype wire

// ===== verif/cfq_host_model.sv
// cfq_host_model: host controller side, issuing command writes and query reads.
// assumes the bench calls its tasks; every request launches just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cfq_host_model
  import cfq_pkg::*;
(
  input wire logic sys_clk_i,
  output logic wr_o,
  output logic [cfq_pkg::CMD_W-1:0] cmd_o,
  output logic rd_o,
  output logic [cfq_pkg::QADDR_W-1:0] addr_o
);
  initial begin
    wr_o = 1'b0;
    cmd_o = 8'h00;
    rd_o = 1'b0;
    addr_o = 9'h000;
  end

  task automatic send_cmd(input logic [CMD_W-1:0] code);
    @(posedge sys_clk_i);
    wr_o <= 1'b1;
    cmd_o <= code;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    // released lines show the inverse so a stale copy never matches
    cmd_o <= ~code;
  endtask : send_cmd

  // stays requesting until go_idle, so reads run back to back
  task automatic read_word(input logic [QADDR_W-1:0] a);
    @(posedge sys_clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
  endtask : read_word

  task automatic go_idle();
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~addr_o;
  endtask : go_idle
endmodule : cfq_host_model
`default_nettype wire

// ===== verif/cfq_geometry_query_test.sv
// cfq_geometry_query_test: self-checking bench for the query read port.
// assumes cfq_host_model drives the host side; expected words come from a bench table.
`timescale 1ns/1ps
`default_nettype none
module cfq_geometry_query_test;
  import cfq_pkg::*;
  logic sys_clk_i;
  logic nrst_i;
  logic clk_en_i;
  logic wr;
  logic [CMD_W-1:0] cmd;
  logic rd;
  logic [QADDR_W-1:0] addr;
  logic [DATA_W-1:0] array_data_i;
  logic [DATA_W-1:0] data_o;
  logic data_oe_o;
  logic rd_valid_o;
  logic query_mode_o;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] exp_v;
  logic [15:0] lfsr_reg;
  logic [CMD_W-1:0] code;
  int err_count;
  int checks_done;
  int cycle_cnt;

  cfq_geometry_query #(.ADDR_W(9), .QUERY_CODE(CMD_QUERY), .ARRAY_CODE(CMD_READ_ARRAY))
  u_cfq_geometry_query (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .wr_i(wr), .cmd_i(cmd),
    .rd_i(rd), .addr_i(addr), .array_data_i(array_data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .rd_valid_o(rd_valid_o), .query_mode_o(query_mode_o)
  );

  cfq_host_model u_cfq_host_model (
    .sys_clk_i(sys_clk_i), .wr_o(wr), .cmd_o(cmd), .rd_o(rd), .addr_o(addr)
  );

  initial begin
    sys_clk_i = 1'b0;
    nrst_i = 1'b0;
    clk_en_i = 1'b1;
    array_data_i = 16'h0000;
    lfsr_reg = 16'h005C;
    err_count = 0;
    checks_done = 0;
    cycle_cnt = 0;
  end

  always #50 sys_clk_i = ~sys_clk_i;

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  // offsets absent from the table read zero, upper lane always zero
  function automatic logic [15:0] exp_word(input logic [QADDR_W-1:0] a);
    case (a)
      9'h027, 9'h116: return 16'h0018;
      9'h028, 9'h029, 9'h113: return 16'h0001;
      9'h02A: return 16'h0006;
      9'h02C, 9'h030: return 16'h0002;
      9'h02D: return 16'h007E;
      9'h031, 9'h110, 9'h114: return 16'h0003;
      9'h033: return 16'h0080;
      9'h10A: return 16'h0050;
      9'h10B: return 16'h0052;
      9'h10C: return 16'h0049;
      9'h10D: return 16'h0031;
      9'h10E: return 16'h0033;
      9'h10F: return 16'h00E6;
      9'h117: return 16'h0090;
      default: return 16'h0000;
    endcase
  endfunction : exp_word

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic mode_is(input logic want);
    repeat (2) @(negedge sys_clk_i);
    check("query_mode_o", {15'h0000, query_mode_o}, {15'h0000, want});
  endtask : mode_is

  // core data held steady across the read so the answer is unambiguous
  task automatic array_read();
    lfsr_reg = lfsr_next(lfsr_reg);
    @(posedge sys_clk_i);
    array_data_i <= lfsr_reg;
    exp_q.push_back(lfsr_reg);
    u_cfq_host_model.read_word(OFF_SIZE_EXP);
    u_cfq_host_model.go_idle();
  endtask : array_read

  always @(posedge sys_clk_i) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  // answers pair with notes in issue order
  always @(posedge sys_clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected_valid", 16'h0001, 16'h0000);
      end else begin
        exp_v = exp_q.pop_front();
        check("data_o", data_o, exp_v);
        check("data_oe_o", {15'h0000, data_oe_o}, 16'h0001);
      end
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(negedge sys_clk_i);
    check("reset_data_o", data_o, 16'h0000);
    check("reset_mode", {15'h0000, query_mode_o}, 16'h0000);
    array_read();
    // foreign codes and disabled edges must not enter query mode
    u_cfq_host_model.send_cmd(8'h00);
    u_cfq_host_model.send_cmd(CMD_READ_ARRAY);
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    u_cfq_host_model.send_cmd(CMD_QUERY);
    // a read seen only on frozen edges is never taken: no note queued
    u_cfq_host_model.read_word(OFF_SIZE_EXP);
    u_cfq_host_model.go_idle();
    @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    mode_is(1'b0);
    u_cfq_host_model.send_cmd(CMD_QUERY);
    mode_is(1'b1);
    for (int i = 0; i < 512; i++) begin
      exp_q.push_back(exp_word(i[8:0]));
      u_cfq_host_model.read_word(i[8:0]);
    end
    for (int i = 0; i < 64; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      exp_q.push_back(exp_word(lfsr_reg[8:0]));
      u_cfq_host_model.read_word(lfsr_reg[8:0]);
    end
    u_cfq_host_model.go_idle();
    for (int i = 0; i < 8; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      code = (lfsr_reg[7:0] == CMD_READ_ARRAY) ? 8'h00 : lfsr_reg[7:0];
      u_cfq_host_model.send_cmd(code);
    end
    mode_is(1'b1);
    u_cfq_host_model.send_cmd(CMD_READ_ARRAY);
    mode_is(1'b0);
    array_read();
    u_cfq_host_model.send_cmd(CMD_QUERY);
    mode_is(1'b1);
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(negedge sys_clk_i);
    check("rerun_mode", {15'h0000, query_mode_o}, 16'h0000);
    check("rerun_valid", {15'h0000, rd_valid_o}, 16'h0000);
    check("rerun_data_o", data_o, 16'h0000);
    repeat (4) @(negedge sys_clk_i);
    check("pending_reads", 16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule : cfq_geometry_query_test
`default_nettype wire
